// ==== core/pmds_pkg.sv ====
// package: constants and state codes for the page-mode dram sequencer
package pmds_pkg;

  // state register codes; the nine codes not listed are unused
  typedef enum logic [3:0] {
    pmds_idle = 4'h0,
    pmds_first_wait = 4'h2,
    pmds_second_wait = 4'h6,
    pmds_access_phase = 4'h4,
    pmds_precharge_phase = 4'h1,
    pmds_page_hold = 4'h8,
    pmds_write_completion = 4'h5
  } pmds_state_t;

  // register byte offsets
  localparam logic [7:0] PMDS_CTRL_OFS = 8'h00;
  localparam logic [7:0] PMDS_STATUS_OFS = 8'h04;
  localparam logic [7:0] PMDS_INPUTS_OFS = 8'h08;
  localparam logic [7:0] PMDS_HITCNT_OFS = 8'h0C;

  // ctrl fields
  localparam int PMDS_CTRL_SEQ_RESET_BIT = 0;
  localparam logic PMDS_CTRL_SEQ_RESET_RST = 1'b0;

  // status fields
  localparam int PMDS_STATUS_STATE_LSB = 0;
  localparam int PMDS_STATUS_BUSY_BIT = 4;
  localparam int PMDS_STATUS_FLAG_BIT = 5;

  // synchronised input vector positions (also inputs register bits)
  localparam int PMDS_IN_MEM_SELECT = 0;
  localparam int PMDS_IN_BUS_INVALID = 1;
  localparam int PMDS_IN_INSTR_REQUEST = 2;
  localparam int PMDS_IN_INSTR_BURST = 3;
  localparam int PMDS_IN_DATA_BURST = 4;
  localparam int PMDS_IN_LENGTH_SELECT = 5;
  localparam int PMDS_IN_ROW_HIT = 6;
  localparam int PMDS_IN_REFRESH = 7;
  localparam int PMDS_IN_COUNT = 8;

  // reset values
  localparam logic PMDS_BUSY_RST = 1'b0;
  localparam logic PMDS_FLAG_RST = 1'b1;

  // ahb
  localparam logic [1:0] PMDS_HTRANS_NONSEQ = 2'b10;
  localparam logic PMDS_HRESP_OKAY = 1'b0;

endpackage : pmds_pkg

// ==== core/pmds_sequencer.sv ====
// page-mode dram access and refresh sequencer with an ahb-lite register slave
// Summary of operation
// - from idle, refresh, valid select or busy advances to first wait
// - idle holds with no refresh, busy clear and no valid select
// - first wait goes to second wait, or idle under sequencer reset
// - second wait goes to access phase, or idle under sequencer reset
// - access with refresh: write completion if flag, short length, busy; else precharge
// - access, no refresh, busy: stay while the matching burst request continues
// - access, no refresh, busy: page hold when the matching burst request is gone
// - access, busy clear, valid new select and row hit: go to second wait
// - access, busy clear, valid new select, no row hit: go to precharge
// - access, busy clear, no valid select: go to page hold
// - precharge always goes to idle next clock
// - page hold to precharge on refresh, or on row miss of an eligible request
// - page hold to second wait on row hit of an eligible request
// - page hold back to access while an instruction burst continues with flag clear
// - page hold holds otherwise; sequencer reset sends it to idle
// - write completion goes to precharge, or idle under sequencer reset
// - any unused state code goes to idle next clock
// - access-type flag holds through waits and, while busy, through access, precharge and idle; reset forces it set
// - state held in four bits with fixed codes
// - busy sets from idle, page hold or access on valid select; holds until cleared
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module pmds_sequencer #(
  parameter int HIT_CNT_W = 16
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // memory side pins, asynchronous to ref_clk_i
  input wire logic mem_select_i,
  input wire logic bus_invalid_i,
  input wire logic instr_request_i,
  input wire logic instr_burst_request_i,
  input wire logic data_burst_request_i,
  input wire logic access_length_select_i,
  input wire logic row_hit_i,
  input wire logic refresh_request_i,
  output logic [3:0] state_o,
  output logic busy_o,
  output logic access_type_flag_o,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o
);

  if (HIT_CNT_W < 1 || HIT_CNT_W > 32) begin : g_bad_width
    $error("HIT_CNT_W must lie between 1 and 32");
  end

  // pin synchronisers: three flops, a change counts once stages two
  // and three agree, which also rejects single-cycle glitches
  logic [pmds_pkg::PMDS_IN_COUNT-1:0] pin_raw;
  logic [pmds_pkg::PMDS_IN_COUNT-1:0] sync1;
  logic [pmds_pkg::PMDS_IN_COUNT-1:0] sync2;
  logic [pmds_pkg::PMDS_IN_COUNT-1:0] sync3;
  logic [pmds_pkg::PMDS_IN_COUNT-1:0] pin_q;

  assign pin_raw[pmds_pkg::PMDS_IN_MEM_SELECT] = mem_select_i;
  assign pin_raw[pmds_pkg::PMDS_IN_BUS_INVALID] = bus_invalid_i;
  assign pin_raw[pmds_pkg::PMDS_IN_INSTR_REQUEST] = instr_request_i;
  assign pin_raw[pmds_pkg::PMDS_IN_INSTR_BURST] = instr_burst_request_i;
  assign pin_raw[pmds_pkg::PMDS_IN_DATA_BURST] = data_burst_request_i;
  assign pin_raw[pmds_pkg::PMDS_IN_LENGTH_SELECT] = access_length_select_i;
  assign pin_raw[pmds_pkg::PMDS_IN_ROW_HIT] = row_hit_i;
  assign pin_raw[pmds_pkg::PMDS_IN_REFRESH] = refresh_request_i;

  for (genvar i = 0; i < pmds_pkg::PMDS_IN_COUNT; i++) begin : g_sync
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
        sync1[i] <= 1'b0;
        sync2[i] <= 1'b0;
        sync3[i] <= 1'b0;
        pin_q[i] <= 1'b0;
      end else begin
        sync1[i] <= pin_raw[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        if (sync2[i] == sync3[i]) begin
          pin_q[i] <= sync3[i];
        end
      end
    end
  end

  logic cs;
  logic bus_invalid;
  logic instr_request;
  logic instr_burst_request;
  logic data_burst_request;
  logic lsel;
  logic hit;
  logic refresh;

  assign cs = pin_q[pmds_pkg::PMDS_IN_MEM_SELECT];
  assign bus_invalid = pin_q[pmds_pkg::PMDS_IN_BUS_INVALID];
  assign instr_request = pin_q[pmds_pkg::PMDS_IN_INSTR_REQUEST];
  assign instr_burst_request = pin_q[pmds_pkg::PMDS_IN_INSTR_BURST];
  assign data_burst_request = pin_q[pmds_pkg::PMDS_IN_DATA_BURST];
  assign lsel = pin_q[pmds_pkg::PMDS_IN_LENGTH_SELECT];
  assign hit = pin_q[pmds_pkg::PMDS_IN_ROW_HIT];
  // held high by the refresh source until its cycle reaches access
  assign refresh = pin_q[pmds_pkg::PMDS_IN_REFRESH];

  // sequencer core
  pmds_pkg::pmds_state_t state;
  pmds_pkg::pmds_state_t next_state;
  logic [3:0] state_raw;
  logic busy;
  logic next_busy;
  logic flag;
  logic next_flag;
  logic seq_reset;
  logic valid_sel;
  logic busy_clear;
  logic st_idle;
  logic st_w1;
  logic st_w2;
  logic st_acc;
  logic st_pc;
  logic st_pm;

  assign state_raw = state;
  assign valid_sel = cs & ~bus_invalid;
  assign st_idle = (state_raw == pmds_pkg::pmds_idle);
  assign st_w1 = (state_raw == pmds_pkg::pmds_first_wait);
  assign st_w2 = (state_raw == pmds_pkg::pmds_second_wait);
  assign st_acc = (state_raw == pmds_pkg::pmds_access_phase);
  assign st_pc = (state_raw == pmds_pkg::pmds_precharge_phase);
  assign st_pm = (state_raw == pmds_pkg::pmds_page_hold);

  always_comb begin
    next_state = pmds_pkg::pmds_idle;
    unique case (state_raw)
      pmds_pkg::pmds_idle: begin
        if (!seq_reset && (refresh || valid_sel || busy)) begin
          next_state = pmds_pkg::pmds_first_wait;
        end else begin
          next_state = pmds_pkg::pmds_idle;
        end
      end
      pmds_pkg::pmds_first_wait: begin
        next_state = seq_reset ? pmds_pkg::pmds_idle : pmds_pkg::pmds_second_wait;
      end
      pmds_pkg::pmds_second_wait: begin
        next_state = seq_reset ? pmds_pkg::pmds_idle : pmds_pkg::pmds_access_phase;
      end
      pmds_pkg::pmds_access_phase: begin
        if (seq_reset) begin
          next_state = pmds_pkg::pmds_idle;
        end else if (refresh) begin
          if (flag && !lsel && busy) begin
            next_state = pmds_pkg::pmds_write_completion;
          end else begin
            next_state = pmds_pkg::pmds_precharge_phase;
          end
        end else if (busy) begin
          if ((!flag && instr_burst_request) || (flag && data_burst_request)) begin
            next_state = pmds_pkg::pmds_access_phase;
          end else begin
            next_state = pmds_pkg::pmds_page_hold;
          end
        end else if (valid_sel) begin
          // a new request on the open row skips the first wait
          next_state = hit ? pmds_pkg::pmds_second_wait : pmds_pkg::pmds_precharge_phase;
        end else begin
          next_state = pmds_pkg::pmds_page_hold;
        end
      end
      pmds_pkg::pmds_precharge_phase: begin
        next_state = pmds_pkg::pmds_idle;
      end
      pmds_pkg::pmds_page_hold: begin
        if (seq_reset) begin
          next_state = pmds_pkg::pmds_idle;
        end else if (refresh) begin
          next_state = pmds_pkg::pmds_precharge_phase;
        end else if ((!busy || instr_request) && valid_sel) begin
          next_state = hit ? pmds_pkg::pmds_second_wait : pmds_pkg::pmds_precharge_phase;
        end else if (busy && instr_burst_request && !flag) begin
          next_state = pmds_pkg::pmds_access_phase;
        end else begin
          next_state = pmds_pkg::pmds_page_hold;
        end
      end
      pmds_pkg::pmds_write_completion: begin
        next_state = seq_reset ? pmds_pkg::pmds_idle : pmds_pkg::pmds_precharge_phase;
      end
      default: begin
        next_state = pmds_pkg::pmds_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= pmds_pkg::pmds_idle;
    end else begin
      state <= next_state;
    end
  end

  // busy clear term, combinational and evaluated in the current state
  assign busy_clear = seq_reset
                    | (st_w2 & flag & ~lsel & ~data_burst_request)
                    | (st_acc & flag & ~data_burst_request)
                    | (st_acc & ~flag & valid_sel)
                    | (st_pm & ~flag & valid_sel)
                    | (st_pm & instr_request & ~cs);

  always_comb begin
    next_busy = (~busy & (st_idle | st_pm | st_acc) & valid_sel & ~seq_reset)
              | (busy & ~busy_clear);
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy <= pmds_pkg::PMDS_BUSY_RST;
    end else begin
      busy <= next_busy;
    end
  end

  // flag: set for data-side cycles chosen at request time, held in the waits and, while busy, in access, precharge and idle
  always_comb begin
    next_flag = ((st_idle | st_pm | st_acc) & ~busy & ~instr_request & valid_sel)
              | (st_pm & busy & instr_request & ~cs)
              | ((st_idle | st_acc) & ~cs & ~busy)
              | (flag & (st_w1 | st_w2 | ((st_acc | st_pc | st_idle) & busy)))
              | seq_reset;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flag <= pmds_pkg::PMDS_FLAG_RST;
    end else begin
      flag <= next_flag;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_o <= 4'h0;
      busy_o <= pmds_pkg::PMDS_BUSY_RST;
      access_type_flag_o <= pmds_pkg::PMDS_FLAG_RST;
    end else begin
      // one cycle behind the internal state so outputs come from flops
      state_o <= state_raw;
      busy_o <= busy;
      access_type_flag_o <= flag;
    end
  end

  // page hits: entries into second wait straight from access or page hold
  logic [HIT_CNT_W-1:0] hit_cnt;
  logic hit_cnt_clr;

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hit_cnt <= '0;
    end else if ((st_acc || st_pm) && next_state == pmds_pkg::pmds_second_wait) begin
      // a hit on the clearing write still counts; saturates, no wrap
      if (hit_cnt != {HIT_CNT_W{1'b1}}) begin
        hit_cnt <= hit_cnt_clr ? HIT_CNT_W'(1) : hit_cnt + HIT_CNT_W'(1);
      end else begin
        hit_cnt <= hit_cnt_clr ? HIT_CNT_W'(1) : hit_cnt;
      end
    end else if (hit_cnt_clr) begin
      hit_cnt <= '0;
    end
  end

  // ahb-lite slave: writes zero wait, reads one wait so that a read
  // right after a write returns the written value
  logic ap_take;
  logic wr_pend;
  logic rd_pend;
  logic [7:0] dp_addr;
  logic [31:0] rd_mux;

  assign ap_take = hsel_i & hready_i & (htrans_i == pmds_pkg::PMDS_HTRANS_NONSEQ);

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      wr_pend <= ap_take & hwrite_i;
      rd_pend <= ap_take & ~hwrite_i;
      if (ap_take) begin
        dp_addr <= {haddr_i[7:2], 2'b00};
      end
    end
  end

  assign hit_cnt_clr = wr_pend && dp_addr == pmds_pkg::PMDS_HITCNT_OFS;

  // software sequencer reset drives the documented reset term
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      seq_reset <= pmds_pkg::PMDS_CTRL_SEQ_RESET_RST;
    end else if (wr_pend && dp_addr == pmds_pkg::PMDS_CTRL_OFS) begin
      seq_reset <= hwdata_i[pmds_pkg::PMDS_CTRL_SEQ_RESET_BIT];
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (dp_addr)
      pmds_pkg::PMDS_CTRL_OFS: begin
        rd_mux[pmds_pkg::PMDS_CTRL_SEQ_RESET_BIT] = seq_reset;
      end
      pmds_pkg::PMDS_STATUS_OFS: begin
        rd_mux[pmds_pkg::PMDS_STATUS_STATE_LSB +: 4] = state_raw;
        rd_mux[pmds_pkg::PMDS_STATUS_BUSY_BIT] = busy;
        rd_mux[pmds_pkg::PMDS_STATUS_FLAG_BIT] = flag;
      end
      pmds_pkg::PMDS_INPUTS_OFS: begin
        rd_mux[pmds_pkg::PMDS_IN_COUNT-1:0] = pin_q;
      end
      pmds_pkg::PMDS_HITCNT_OFS: begin
        rd_mux[HIT_CNT_W-1:0] = hit_cnt;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= pmds_pkg::PMDS_HRESP_OKAY;
    end else begin
      hresp_o <= pmds_pkg::PMDS_HRESP_OKAY;
      if (ap_take && !hwrite_i) begin
        hreadyout_o <= 1'b0;
      end else if (rd_pend) begin
        hrdata_o <= rd_mux;
        hreadyout_o <= 1'b1;
      end
    end
  end

endmodule : pmds_sequencer

`default_nettype wire

// ==== tb/pmds_sequencer_sva.sv ====
// port checker for the page-mode dram sequencer
`timescale 1ns/1ps
`default_nettype none
module pmds_sequencer_sva (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] state_o,
  input wire logic busy_o,
  input wire logic access_type_flag_o,
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_idle_exit_order: assert property (state_o == 4'h0 |=> state_o inside {4'h0, 4'h2})
    else $error("idle left for a state other than first wait");
  a_first_wait_next: assert property (state_o == 4'h2 |=> state_o inside {4'h6, 4'h0})
    else $error("first wait not followed by second wait or idle");
  a_second_wait_next: assert property (state_o == 4'h6 |=> state_o inside {4'h4, 4'h0})
    else $error("second wait not followed by access or idle");
  a_precharge_to_idle: assert property (state_o == 4'h1 |=> state_o == 4'h0)
    else $error("precharge not followed by idle");
  a_wc_to_precharge: assert property (state_o == 4'h5 |=> state_o inside {4'h1, 4'h0})
    else $error("write completion not followed by precharge or idle");
  a_state_code_legal: assert property (state_o inside {4'h0, 4'h2, 4'h6, 4'h4, 4'h1, 4'h8, 4'h5})
    else $error("unused state code shown");
  a_reset_values: assert property ($rose(reset_n_i) |-> state_o == 4'h0 && !busy_o && access_type_flag_o)
    else $error("wrong values after reset release");
  a_flag_wait_hold: assert property (state_o == 4'h2 && access_type_flag_o |=> access_type_flag_o)
    else $error("access-type flag lost in first wait");
  a_busy_set_source: assert property ($rose(busy_o) |-> $past(state_o) inside {4'h0, 4'h8, 4'h4})
    else $error("busy set from a state that may not set it");
  a_read_one_wait: assert property (hsel_i && hready_i && htrans_i == 2'b10 && !hwrite_i
    |=> !hreadyout_o ##1 hreadyout_o && !hresp_o)
    else $error("read answer not after exactly one wait cycle");
endmodule : pmds_sequencer_sva

bind pmds_sequencer pmds_sequencer_sva u_pmds_sequencer_sva (
  .ref_clk_i(ref_clk_i),
  .reset_n_i(reset_n_i),
  .state_o(state_o),
  .busy_o(busy_o),
  .access_type_flag_o(access_type_flag_o),
  .hsel_i(hsel_i),
  .htrans_i(htrans_i),
  .hwrite_i(hwrite_i),
  .hready_i(hready_i),
  .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o)
);
`default_nettype wire

// ==== tb/pmds_far_model.sv ====
// far-side refresh requester that holds its request until served
`timescale 1ns/1ps
`default_nettype none
module pmds_far_model (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic refresh_go_i,
  input wire logic [3:0] state_i,
  output logic refresh_request_o
);
  logic armed;
  // only a cycle started after the raise may withdraw it, else a running access would
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      refresh_request_o <= 1'b0;
      armed <= 1'b0;
    end else if (refresh_go_i) begin
      refresh_request_o <= 1'b1;
      armed <= 1'b0;
    end else if (refresh_request_o && state_i == 4'h2) begin
      armed <= 1'b1;
    end else if (armed && state_i == 4'h4) begin
      refresh_request_o <= 1'b0;
      armed <= 1'b0;
    end
  end
endmodule : pmds_far_model
`default_nettype wire

// ==== tb/tb.sv ====
// testbench for the page-mode dram sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk_i, reset_n_i, sel, bus_invalid, dburst, hit, go, rfsh, instr_burst_request;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic hwrite, hready, hresp, busy, flag;
  logic [31:0] hwdata, hrdata, d;
  logic [3:0] state;
  int bad_count = 0;
  int comparisons = 0;

  pmds_sequencer u_pmds_sequencer (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .mem_select_i(sel), .bus_invalid_i(bus_invalid),
    .instr_request_i(1'b0), .instr_burst_request_i(instr_burst_request), .data_burst_request_i(dburst),
    .access_length_select_i(1'b0), .row_hit_i(hit), .refresh_request_i(rfsh), .state_o(state),
    .busy_o(busy), .access_type_flag_o(flag), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp));
  pmds_far_model u_pmds_far_model (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .refresh_go_i(go), .state_i(state), .refresh_request_o(rfsh));

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge ref_clk_i);
    while (hready !== 1'b1) @(posedge ref_clk_i);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge ref_clk_i);
    while (hready !== 1'b1) @(posedge ref_clk_i);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : ahb

  task automatic wait_state(input logic [3:0] s);
    int n;
    n = 0;
    while (state !== s && n < 60) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk("state", {28'h0, s}, {28'h0, state});
  endtask : wait_state

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test

  task automatic complete_run;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    bad_count++;
    complete_run();
  end

  initial begin
    {reset_n_i, sel, bus_invalid, dburst, hit, go, hwrite, instr_burst_request} = 8'h00;
    haddr = 8'h00;
    htrans = 2'b00;
    hwdata = 32'h0;
    repeat (3) @(posedge ref_clk_i);
    chk("reset outs", 32'h3, {25'h0, state, busy, flag, hready});
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    ahb(8'h00, 1'b0, 32'h0, d);
    chk("ctrl", 32'h0, d);
    ahb(8'h10, 1'b0, 32'h0, d);
    chk("unmapped", 32'h0, d);
    sel <= 1'b1;
    bus_invalid <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    chk("state", 32'h0, {28'h0, state});
    end_test("invalid");
    bus_invalid <= 1'b0;
    dburst <= 1'b1;
    wait_state(4'h2);
    wait_state(4'h6);
    wait_state(4'h4);
    repeat (10) @(posedge ref_clk_i);
    ahb(8'h04, 1'b0, 32'h0, d);
    chk("status", 32'h34, d);
    go <= 1'b1;
    @(posedge ref_clk_i);
    go <= 1'b0;
    wait_state(4'h5);
    wait_state(4'h1);
    wait_state(4'h0);
    wait_state(4'h4);
    sel <= 1'b0;
    dburst <= 1'b0;
    wait_state(4'h8);
    repeat (10) @(posedge ref_clk_i);
    chk("state", 32'h8, {28'h0, state});
    ahb(8'h04, 1'b0, 32'h0, d);
    chk("status", 32'h18, d);
    instr_burst_request <= 1'b1;
    wait_state(4'h4);
    repeat (10) @(posedge ref_clk_i);
    chk("state", 32'h4, {28'h0, state});
    instr_burst_request <= 1'b0;
    wait_state(4'h8);
    end_test("burst");
    hit <= 1'b1;
    sel <= 1'b1;
    wait_state(4'h6);
    sel <= 1'b0;
    wait_state(4'h8);
    hit <= 1'b0;
    sel <= 1'b1;
    wait_state(4'h1);
    sel <= 1'b0;
    wait_state(4'h0);
    repeat (20) @(posedge ref_clk_i);
    wait_state(4'h8);
    go <= 1'b1;
    @(posedge ref_clk_i);
    go <= 1'b0;
    wait_state(4'h1);
    wait_state(4'h4);
    wait_state(4'h1);
    end_test("page");
    sel <= 1'b1;
    dburst <= 1'b1;
    wait_state(4'h4);
    ahb(8'h00, 1'b1, 32'h1, d);
    repeat (6) @(posedge ref_clk_i);
    chk("state", 32'h0, {28'h0, state});
    ahb(8'h04, 1'b0, 32'h0, d);
    chk("status", 32'h20, d);
    ahb(8'h08, 1'b0, 32'h0, d);
    chk("inputs", 32'h11, d);
    ahb(8'h00, 1'b0, 32'h0, d);
    chk("ctrl", 32'h1, d);
    sel <= 1'b0;
    dburst <= 1'b0;
    ahb(8'h00, 1'b1, 32'h0, d);
    ahb(8'h0C, 1'b1, 32'h0, d);
    ahb(8'h0C, 1'b0, 32'h0, d);
    chk("hitcnt", 32'h0, d);
    end_test("seq reset");
    reset_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    chk("reset outs", 32'h3, {25'h0, state, busy, flag, hready});
    reset_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    end_test("hard reset");
    complete_run();
  end
endmodule : tb
`default_nettype wire
